// File: logic/rsi_consts.svh
// Purpose: Offsets, field positions and reset values of the receive serializer block
// Assumes: Six-bit register addresses on the serial host port
// Notes:   Definitions only
`ifndef RSI_CONSTS_SVH
`define RSI_CONSTS_SVH
`define RSI_ADDR_CFG      6'h05
`define RSI_ADDR_CTL      6'h06
`define RSI_ADDR_IEN      6'h07
`define RSI_ADDR_STAT     6'h08
`define RSI_ADDR_DATA_A   6'h09
`define RSI_ADDR_DATA_B   6'h0b
`define RSI_RST_CFG       2'h1
`define RSI_RST_CTL       4'h3
`define RSI_RST_IEN       8'h00
`define RSI_CTL_BYTE_BIT  3
`define RSI_CMD_WR_BIT    7
`define RSI_IEN_FULL      0
`define RSI_IEN_EOF       1
`define RSI_IEN_OVF       2
`define RSI_IEN_UNF       3
`define RSI_ST_FULL       0
`define RSI_ST_EOF        1
`define RSI_ST_FLOW       2
`define RSI_ST_VALID      3
`define RSI_CH_STRIDE     4
`define RSI_PIN_OPEN_SRC  2'h3
`define RSI_PIN_OPEN_DRN  2'h2
`define RSI_PIN_CMOS      2'h1
`define RSI_PIN_CMOS_INV  2'h0
`define RSI_FIFO_DEPTH    8
`define RSI_BYTE_BITS     4'h8
`define RSI_SPI_BITS      5'h10
`define RSI_SPI_ADDR_BITS 5'h08
`endif

// File: logic/rsi_pkg.sv
// Purpose: Types shared by the receive serializer block
// Assumes: Constants come from rsi_consts.svh
// Notes:   One bit-time event per FIFO word
package rsi_pkg;
	// One correlator bit time for one channel
	typedef struct packed {
		logic chan;
		logic valid;
		logic data;
	} rsi_bit_s;

	typedef enum logic [1:0] {
		RSI_SPI_IDLE,
		RSI_SPI_ADDR,
		RSI_SPI_DATA
	} rsi_spi_e;
endpackage : rsi_pkg

// File: logic/rsi_rx_serdes_irq.sv
// Purpose: Receive deserializer, end-of-frame detection, status and interrupt pin drive
// Assumes: Correlator events arrive on the system clock; host port pins are asynchronous
// Notes:   Host frame is command byte (bit 7 write, bits 5:0 address) then one data byte
// Behaviour
// R1: Select 11 drives pin high when asserted, 10 drives low; otherwise floats.
// R2: Select 01 drives high asserted, low idle; 00 drives low asserted, high idle.
// R3: Host writes zeros to every reserved bit of the three control registers.
// R4: Byte mode bit picks byte transfers through data registers or bit-serial pins.
// R5: In bit-serial mode the host handles each bit over the serial pins; only channel A bits reach the pins.
// R6: Three-bit gap length sets invalid bit times before end of frame.
// R7: End-of-frame detection arms in receive mode after one valid bit.
// R8: End of frame moves accumulated bits to that channel's data register.
// R9: Gap length zero ends the frame at the first invalid bit.
// R10: Channels A and B have own data registers at 0x09 and 0x0b.
// R11: Bits 7 and 3 enable underflow, reading an empty data register.
// R12: Bits 6 and 2 enable overflow, loading before the previous byte was read.
// R13: Bits 5 and 1 enable end-of-frame interrupt once gap length exceeded.
// R14: Reading the receive status register clears pending end of frame.
// R15: Bits 4 and 0 enable full interrupt, raised on every data transfer.
// R16: Transfer happens on a complete byte or on end of frame with partial byte.
// R17: Status bits set regardless of enables; read zero outside receive mode.
// R18: Reading status at 0x08 clears each channel's flow violation flag.
// R19: Pin asserts while any enabled pending condition exists, else deasserts. The code asserts it in receive mode only.
// R20: Disabling an enable masks only the pin; pending status keeps tracking.
`timescale 1ns/1ps
`include "rsi_consts.svh"

// Parameterised FIFO between correlator and deserializer
module rsi_fifo #(
	parameter int WIDTH = 3,
	parameter int DEPTH = 8
) (
	input  wire logic             clock,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic [WIDTH-1:0]      out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic [AW:0]      next_count;
	wire              push = in_valid && in_ready;
	wire              pop  = out_valid && out_ready;

	assign next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	assign out_valid  = (count != '0);
	assign out_data   = mem[rd_ptr];

	// Ready is a flop fed from the next count, so it is exact without comb output
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wr_ptr   <= '0;
			rd_ptr   <= '0;
			count    <= '0;
			in_ready <= 1'b1;
		end else begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
			count    <= next_count;
			in_ready <= (next_count != DEPTH[AW:0]);
		end
	end

	// Storage has no reset, only valid entries are ever read
	always_ff @(posedge clock) begin
		if (push)
			mem[wr_ptr] <= in_data;
	end
endmodule : rsi_fifo

module rsi_rx_serdes_irq
	import rsi_pkg::*;
(
	input  wire logic     clock,
	input  wire logic     rst,
	input  wire logic     rx_mode,
	input  wire rsi_bit_s bit_event,
	input  wire logic     bit_event_valid,
	output logic          bit_event_ready,
	input  wire logic     host_sck,
	input  wire logic     host_sel_n,
	input  wire logic     host_mosi,
	output logic          host_miso,
	output logic          host_miso_oe,
	output logic          serial_data_pin,
	output logic          serial_data_valid_pin,
	output logic          irq_out,
	output logic          irq_oe
);
	// Registers
	logic [1:0]  pin_sel;
	logic [3:0]  ctl;
	logic [7:0]  ien;
	// Per channel state
	logic [7:0]  shreg    [2];
	logic [3:0]  nbits    [2];
	logic [2:0]  gap      [2];
	logic        armed    [2];
	logic [7:0]  data_reg [2];
	logic        has_data [2];
	logic [3:0]  st       [2];
	logic        unf_pend [2];
	logic        ovf_pend [2];
	// Host port
	logic [2:0]  sck_s;
	logic [2:0]  sel_s;
	logic [2:0]  mosi_s;
	logic        sck_f;
	logic        sck_d;
	logic        sel_f;
	logic        mosi_f;
	rsi_spi_e    spi_st;
	logic [4:0]  spi_cnt;
	logic [7:0]  spi_sh;
	logic [7:0]  spi_cmd;
	logic [7:0]  miso_sh;

	wire         byte_mode = ctl[`RSI_CTL_BYTE_BIT];
	wire [2:0]   eof_len   = ctl[2:0];
	wire         sck_rise  = sck_f && !sck_d && !sel_f;
	wire         sck_fall  = !sck_f && sck_d && !sel_f;
	wire [7:0]   rx_byte   = {spi_sh[6:0], mosi_f};
	wire         addr_done = sck_rise && (spi_st == RSI_SPI_ADDR)
	                         && (spi_cnt == `RSI_SPI_ADDR_BITS - 5'h01);
	wire         data_done = sck_rise && (spi_st == RSI_SPI_DATA)
	                         && (spi_cnt == `RSI_SPI_BITS - 5'h01);
	wire [5:0]   cmd_addr  = rx_byte[5:0];
	wire         cmd_rd    = addr_done && !rx_byte[`RSI_CMD_WR_BIT];
	wire         wr_stb    = data_done && spi_cmd[`RSI_CMD_WR_BIT];
	wire         rd_stat   = cmd_rd && (cmd_addr == `RSI_ADDR_STAT);
	wire [1:0]   rd_data   = {cmd_rd && (cmd_addr == `RSI_ADDR_DATA_B),
	                          cmd_rd && (cmd_addr == `RSI_ADDR_DATA_A)};
	wire [5:0]   wr_addr   = spi_cmd[5:0];
	// Hold the drain during a read snapshot so side effects stay atomic
	wire         drain     = !cmd_rd;
	rsi_bit_s    ev;
	logic        ev_valid;
	wire [7:0]   status;
	wire [7:0]   rd_value;
	wire [7:0]   pend;
	wire         irq_req;

	// Correlator events queue here; back-pressure reaches the source
	rsi_fifo #(
		.WIDTH ($bits(rsi_bit_s)),
		.DEPTH (`RSI_FIFO_DEPTH)
	) u_fifo (
		.clock     (clock),
		.rst       (rst),
		.in_data   (bit_event),
		.in_valid  (bit_event_valid),
		.in_ready  (bit_event_ready),
		.out_data  (ev),
		.out_valid (ev_valid),
		.out_ready (drain)
	);

	// Three-stage sync; a level counts once stages two and three agree
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sck_s  <= 3'h0;
			sel_s  <= 3'h7;
			mosi_s <= 3'h0;
			sck_f  <= 1'b0;
			sck_d  <= 1'b0;
			sel_f  <= 1'b1;
			mosi_f <= 1'b0;
		end else begin
			sck_s  <= {sck_s[1:0], host_sck};
			sel_s  <= {sel_s[1:0], host_sel_n};
			mosi_s <= {mosi_s[1:0], host_mosi};
			sck_d  <= sck_f;
			if (sck_s[1] == sck_s[2])
				sck_f <= sck_s[2];
			if (sel_s[1] == sel_s[2])
				sel_f <= sel_s[2];
			if (mosi_s[1] == mosi_s[2])
				mosi_f <= mosi_s[2];
		end
	end

	// Host frame sequencer, deselect aborts any frame
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			spi_st  <= RSI_SPI_IDLE;
			spi_cnt <= 5'h00;
			spi_sh  <= 8'h00;
			spi_cmd <= 8'h00;
		end else begin
			case (spi_st)
				RSI_SPI_IDLE: begin
					spi_cnt <= 5'h00;
					if (!sel_f)
						spi_st <= RSI_SPI_ADDR;
				end
				RSI_SPI_ADDR, RSI_SPI_DATA: begin
					if (sel_f) begin
						spi_st <= RSI_SPI_IDLE;
					end else if (sck_rise) begin
						spi_sh  <= rx_byte;
						spi_cnt <= (spi_cnt == `RSI_SPI_BITS - 5'h01) ? 5'h00
						           : spi_cnt + 5'h01;
						if (addr_done) begin
							spi_cmd <= rx_byte;
							spi_st  <= RSI_SPI_DATA;
						end
						if (data_done)
							spi_st <= RSI_SPI_ADDR;
					end
				end
				default: spi_st <= RSI_SPI_IDLE;
			endcase
		end
	end

	// R10: own data register per channel; unmapped addresses read zero
	assign rd_value = (cmd_addr == `RSI_ADDR_CFG)    ? {6'h00, pin_sel} :
	                  (cmd_addr == `RSI_ADDR_CTL)    ? {4'h0, ctl} :
	                  (cmd_addr == `RSI_ADDR_IEN)    ? ien :
	                  (cmd_addr == `RSI_ADDR_STAT)   ? status :
	                  (cmd_addr == `RSI_ADDR_DATA_A) ? data_reg[0] :
	                  (cmd_addr == `RSI_ADDR_DATA_B) ? data_reg[1] : 8'h00;

	// Read data shifts out msb first on falling clock edges
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			miso_sh      <= 8'h00;
			host_miso    <= 1'b0;
			host_miso_oe <= 1'b0;
		end else begin
			host_miso_oe <= !sel_f;
			if (cmd_rd)
				miso_sh <= rd_value;
			else if (sck_fall && spi_st == RSI_SPI_DATA) begin
				host_miso <= miso_sh[7];
				miso_sh   <= {miso_sh[6:0], 1'b0};
			end
		end
	end

	// Writes keep only defined fields, reserved bits are left to the host
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pin_sel <= `RSI_RST_CFG;
			ctl     <= `RSI_RST_CTL;
			ien     <= `RSI_RST_IEN;
		end else if (wr_stb) begin
			// R3: reserved bits dropped
			if (wr_addr == `RSI_ADDR_CFG)
				pin_sel <= rx_byte[1:0];
			if (wr_addr == `RSI_ADDR_CTL)
				ctl <= rx_byte[3:0];
			if (wr_addr == `RSI_ADDR_IEN)
				ien <= rx_byte;
		end
	end

	// Bit-serial mode forwards channel A bit times to the serial pins
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			serial_data_pin       <= 1'b0;
			serial_data_valid_pin <= 1'b0;
		end else begin
			// R4: serial pins used only without byte mode
			serial_data_valid_pin <= 1'b0;
			if (ev_valid && drain && !byte_mode && rx_mode && !ev.chan) begin
				serial_data_pin       <= ev.data;
				serial_data_valid_pin <= ev.valid;
			end
		end
	end

	// Per channel deserializer, gap counter and sticky status
	genvar c;
	generate
		for (c = 0; c < 2; c++) begin : g_ch
			wire hit      = ev_valid && drain && (ev.chan == 1'(c)) && rx_mode && byte_mode;
			wire good     = hit && ev.valid;
			wire bad      = hit && !ev.valid && armed[c];
			// R9: zero length ends at the first invalid bit
			wire eof_ev   = bad && (gap[c] == eof_len);
			wire byte_end = good && (nbits[c] == `RSI_BYTE_BITS - 4'h1);
			// R16: full byte or partial byte at end of frame
			wire xfer     = byte_end || (eof_ev && nbits[c] != 4'h0);
			wire [7:0] xbyte = byte_end ? {shreg[c][6:0], ev.data} : shreg[c];
			wire full_byte   = byte_end;
			wire rd_empty    = rd_data[c] && !has_data[c];

			always_ff @(posedge clock or posedge rst) begin
				if (rst) begin
					shreg[c] <= 8'h00;
					nbits[c] <= 4'h0;
					gap[c]   <= 3'h0;
					armed[c] <= 1'b0;
				end else if (!rx_mode) begin
					nbits[c] <= 4'h0;
					gap[c]   <= 3'h0;
					armed[c] <= 1'b0;
				end else if (good) begin
					// R7: armed by a valid bit, gap restarts
					shreg[c] <= {shreg[c][6:0], ev.data};
					nbits[c] <= byte_end ? 4'h0 : nbits[c] + 4'h1;
					gap[c]   <= 3'h0;
					armed[c] <= 1'b1;
				end else if (bad) begin
					// R6: count invalid bit times up to the gap length
					gap[c] <= eof_ev ? 3'h0 : gap[c] + 3'h1;
					if (eof_ev) begin
						armed[c] <= 1'b0;
						nbits[c] <= 4'h0;
					end
				end
			end

			// R8: frame end with a partial byte, or a full byte, loads the channel data register
			always_ff @(posedge clock or posedge rst) begin
				if (rst) begin
					data_reg[c] <= 8'h00;
					has_data[c] <= 1'b0;
				end else if (xfer) begin
					data_reg[c] <= xbyte;
					has_data[c] <= 1'b1;
				end else if (rd_data[c]) begin
					has_data[c] <= 1'b0;
				end
			end

			// Sticky flags: a set in the clearing cycle wins over the clear
			always_ff @(posedge clock or posedge rst) begin
				if (rst) begin
					st[c]       <= 4'h0;
					unf_pend[c] <= 1'b0;
					ovf_pend[c] <= 1'b0;
				end else begin
					// R15: every transfer raises full; a data read clears it
					st[c][`RSI_ST_FULL] <= xfer || (st[c][`RSI_ST_FULL] && !rd_data[c]);
					// R14: status read clears end of frame
					st[c][`RSI_ST_EOF]  <= eof_ev || (st[c][`RSI_ST_EOF] && !rd_stat);
					if (xfer)
						st[c][`RSI_ST_VALID] <= full_byte;
					// R12: load while previous byte unread
					ovf_pend[c] <= (xfer && has_data[c]) || (ovf_pend[c] && !rd_stat);
					// R11: read of an empty data register
					unf_pend[c] <= rd_empty || (unf_pend[c] && !rd_stat);
					// R18: status read clears the flow flag
					st[c][`RSI_ST_FLOW] <= (xfer && has_data[c]) || rd_empty
					                       || (st[c][`RSI_ST_FLOW] && !rd_stat);
				end
			end

			// R17: status reads zero outside receive mode
			assign status[c*`RSI_CH_STRIDE +: `RSI_CH_STRIDE] = rx_mode ? st[c] : 4'h0;
			// R20: enables gate only the pin, flags keep tracking
			assign pend[c*`RSI_CH_STRIDE + `RSI_IEN_FULL] =
				st[c][`RSI_ST_FULL] && ien[c*`RSI_CH_STRIDE + `RSI_IEN_FULL];
			// R13: end-of-frame enable
			assign pend[c*`RSI_CH_STRIDE + `RSI_IEN_EOF] =
				st[c][`RSI_ST_EOF] && ien[c*`RSI_CH_STRIDE + `RSI_IEN_EOF];
			assign pend[c*`RSI_CH_STRIDE + `RSI_IEN_OVF] =
				ovf_pend[c] && ien[c*`RSI_CH_STRIDE + `RSI_IEN_OVF];
			assign pend[c*`RSI_CH_STRIDE + `RSI_IEN_UNF] =
				unf_pend[c] && ien[c*`RSI_CH_STRIDE + `RSI_IEN_UNF];
		end
	endgenerate

	// R19: any enabled pending condition asserts the pin, in receive mode only
	assign irq_req = rx_mode && (pend != 8'h00);

	// Pin drive; level and enable both registered
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			irq_out <= 1'b0;
			irq_oe  <= 1'b1;
		end else begin
			case (pin_sel)
				// R1: open source and open drain float when idle
				`RSI_PIN_OPEN_SRC: begin
					irq_out <= 1'b1;
					irq_oe  <= irq_req;
				end
				`RSI_PIN_OPEN_DRN: begin
					irq_out <= 1'b0;
					irq_oe  <= irq_req;
				end
				// R2: push-pull, true and inverted
				`RSI_PIN_CMOS: begin
					irq_out <= irq_req;
					irq_oe  <= 1'b1;
				end
				default: begin
					irq_out <= !irq_req;
					irq_oe  <= 1'b1;
				end
			endcase
		end
	end
endmodule : rsi_rx_serdes_irq

// File: dv/rsi_rx_serdes_irq_sva.sv
// Purpose: Port checks of the receive serializer block
// Assumes: One clock domain, reset rst
// Notes:   Quiet counter replaces long stability windows
`timescale 1ns/1ps
module rsi_rx_serdes_irq_sva (
	input wire logic clock,
	input wire logic rst,
	input wire logic rx_mode,
	input wire logic bit_event_valid,
	input wire logic bit_event_ready,
	input wire logic host_sel_n,
	input wire logic host_miso_oe,
	input wire logic serial_data_valid_pin,
	input wire logic irq_out,
	input wire logic irq_oe
);
	logic [4:0] quiet;
	logic [4:0] ev_age;
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	// Cycles since anything that may move the pin; saturates
	always_ff @(posedge clock or posedge rst) begin
		if (rst) quiet <= 5'h00;
		else if (bit_event_valid || !host_sel_n || $changed(rx_mode)) quiet <= 5'h00;
		else if (quiet != 5'h1f) quiet <= quiet + 5'h01;
	end
	// Cycles since bit_event_valid was last high
	always_ff @(posedge clock or posedge rst) begin
		if (rst) ev_age <= 5'h1f;
		else if (bit_event_valid) ev_age <= 5'h00;
		else if (ev_age != 5'h1f) ev_age <= ev_age + 5'h01;
	end
	property p_oe_off; host_sel_n [*6] |-> !host_miso_oe; endproperty
	property p_oe_on; !host_sel_n [*6] |-> host_miso_oe; endproperty
	property p_ready; !bit_event_valid [*2] |-> bit_event_ready; endproperty
	property p_style; quiet > 5'h02 |-> !($changed(irq_out) && $changed(irq_oe)); endproperty
	property p_quiet; quiet > 5'h14 |-> $stable(irq_out) && $stable(irq_oe); endproperty
	property p_rx_off; !rx_mode [*3] |-> !serial_data_valid_pin; endproperty
	property p_ser_cause; serial_data_valid_pin |-> ev_age < 5'h10; endproperty
	property p_off_hold;
		(!rx_mode && host_sel_n) [*6] |-> $stable(irq_out) && $stable(irq_oe);
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("miso driven while deselected");
	a_oe_on: assert property (p_oe_on) else $error("miso not driven while selected");
	a_ready: assert property (p_ready) else $error("fifo stuck full");
	a_style: assert property (p_style) else $error("level and drive moved together");
	a_quiet: assert property (p_quiet) else $error("irq pin moved without cause");
	a_rx_off: assert property (p_rx_off) else $error("serial pulse outside receive");
	a_ser_cause: assert property (p_ser_cause) else $error("serial pulse without event");
	a_off_hold: assert property (p_off_hold) else $error("irq moved outside receive");
	c_float: cover property (!irq_oe);
	c_serial: cover property (serial_data_valid_pin);
	c_clear: cover property ($fell(irq_out));
endmodule : rsi_rx_serdes_irq_sva

bind rsi_rx_serdes_irq rsi_rx_serdes_irq_sva u_sva (.clock(clock), .rst(rst),
	.rx_mode(rx_mode), .bit_event_valid(bit_event_valid), .bit_event_ready(bit_event_ready),
	.host_sel_n(host_sel_n), .host_miso_oe(host_miso_oe),
	.serial_data_valid_pin(serial_data_valid_pin), .irq_out(irq_out), .irq_oe(irq_oe));

// File: dv/rsi_host_model.sv
// Purpose: Host side of the serial register port
// Assumes: Mode 0, 800 ns serial period, msb first
// Notes:   Changes land on falling system clock edges
`timescale 1ns/1ps
module rsi_host_model (
	input  wire logic clock,
	input  wire logic host_miso,
	output logic      host_sck,
	output logic      host_sel_n,
	output logic      host_mosi
);
	// Idle: deselected, serial clock low
	initial begin
		host_sck = 1'b0;
		host_sel_n = 1'b1;
		host_mosi = 1'b0;
	end
	// Command byte then data byte; read data sampled late in each high phase
	task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] rd);
		logic [15:0] sh;
		sh = {cmd, wd};
		rd = 8'h00;
		@(negedge clock);
		host_sel_n = 1'b0;
		#400;
		for (int i = 15; i >= 0; i--) begin
			host_mosi = sh[i];
			#400;
			host_sck = 1'b1;
			#390;
			if (i < 8) rd = {rd[6:0], host_miso};
			#10;
			host_sck = 1'b0;
		end
		#400;
		host_sel_n = 1'b1;
		// Released line flips so a stale bit never passes for a driven one
		host_mosi = ~host_mosi;
		#800;
	endtask : xfer
endmodule : rsi_host_model

// File: dv/testbench.sv
// Purpose: Register and event sequences for the receive serializer block
// Assumes: Host model speaks the serial register port
// Notes:   FIFO drains each clock except in a read command cycle, so it is never seen full
`timescale 1ns/1ps
`include "rsi_consts.svh"
module testbench
	import rsi_pkg::*;
;
	logic     clock, rst, rx_mode, bit_event_valid, host_sck, host_sel_n, host_mosi;
	rsi_bit_s bit_event;
	wire      bit_event_ready, host_miso, host_miso_oe, serial_data_pin;
	wire      serial_data_valid_pin, irq_out, irq_oe;
	int       n_mismatch = 0;
	int       tests_run = 0;
	int       cycles = 0;
	int       ser_cnt = 0;
	int       c0;
	logic     ser_bit = 1'b0;
	logic [7:0] rv;

	rsi_rx_serdes_irq u_dut (.clock(clock), .rst(rst), .rx_mode(rx_mode),
		.bit_event(bit_event), .bit_event_valid(bit_event_valid),
		.bit_event_ready(bit_event_ready), .host_sck(host_sck), .host_sel_n(host_sel_n),
		.host_mosi(host_mosi), .host_miso(host_miso), .host_miso_oe(host_miso_oe),
		.serial_data_pin(serial_data_pin), .serial_data_valid_pin(serial_data_valid_pin),
		.irq_out(irq_out), .irq_oe(irq_oe));
	rsi_host_model u_host (.clock(clock), .host_miso(host_miso), .host_sck(host_sck),
		.host_sel_n(host_sel_n), .host_mosi(host_mosi));

	// Clock and hang guard
	always #50 clock = ~clock;
	always @(posedge clock) begin
		cycles++;
		if (cycles == 30000) begin
			n_mismatch++;
			summarize();
		end
	end
	// Bit-serial pulses seen on the pins, sampled mid-cycle where they are settled
	always @(negedge clock) begin
		if (serial_data_valid_pin === 1'b1) begin
			ser_cnt++;
			ser_bit = serial_data_pin;
		end
	end

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		u_host.xfer({2'b10, a}, d, rv);
	endtask : wr
	task automatic rd_raw(input logic [5:0] a);
		u_host.xfer({2'b00, a}, 8'h00, rv);
	endtask : rd_raw
	task automatic rd(input logic [5:0] a, input logic [7:0] exp);
		rd_raw(a);
		chk($sformatf("reg %h", a), exp, rv);
	endtask : rd
	// Level is looked at only while the pin is driven
	task automatic pin(input logic o, input logic e);
		chk("irq drive", {7'h00, e}, {7'h00, irq_oe});
		if (e) chk("irq level", {7'h00, o}, {7'h00, irq_out});
	endtask : pin
	// Bit times msb first, then let the FIFO drain
	task automatic push(input logic ch, input logic v, input logic [7:0] b, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			@(negedge clock);
			while (bit_event_ready !== 1'b1) @(negedge clock);
			bit_event_valid = 1'b1;
			bit_event = '{chan: ch, valid: v, data: b[i]};
			@(posedge clock);
		end
		@(negedge clock);
		bit_event_valid = 1'b0;
		repeat (12) @(negedge clock);
	endtask : push
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : summarize

	initial begin
		clock = 1'b0;
		rst = 1'b1;
		rx_mode = 1'b0;
		bit_event_valid = 1'b0;
		bit_event = '0;
		repeat (20) @(negedge clock);
		rst = 1'b0;
		pin(1'b0, 1'b1);
		rd(`RSI_ADDR_CFG, 8'h01);
		rd(`RSI_ADDR_CTL, 8'h03);
		rd(`RSI_ADDR_IEN, 8'h00);
		rd(6'h3f, 8'h00);
		$display("test reset values done");
		rx_mode = 1'b1;
		// reserved bits written as zero throughout
		wr(`RSI_ADDR_CTL, 8'h0a);
		wr(`RSI_ADDR_IEN, 8'h01);
		push(1'b0, 1'b1, 8'ha5, 8);
		pin(1'b1, 1'b1);
		rd(`RSI_ADDR_STAT, 8'h09);
		rd(`RSI_ADDR_DATA_A, 8'ha5);
		pin(1'b0, 1'b1);
		$display("test full byte done");
		wr(`RSI_ADDR_IEN, 8'h02);
		push(1'b0, 1'b1, 8'h05, 3);
		push(1'b0, 1'b0, 8'h00, 2);
		pin(1'b0, 1'b1);
		push(1'b0, 1'b0, 8'h00, 1);
		pin(1'b1, 1'b1);
		rd(`RSI_ADDR_STAT, 8'h03);
		pin(1'b0, 1'b1);
		rd_raw(`RSI_ADDR_DATA_A);
		rd(`RSI_ADDR_STAT, 8'h00);
		$display("test gap length two done");
		wr(`RSI_ADDR_CTL, 8'h08);
		wr(`RSI_ADDR_IEN, 8'h20);
		push(1'b1, 1'b1, 8'h01, 1);
		push(1'b1, 1'b0, 8'h00, 1);
		pin(1'b1, 1'b1);
		rd(`RSI_ADDR_STAT, 8'h30);
		rd_raw(`RSI_ADDR_DATA_B);
		rd(`RSI_ADDR_STAT, 8'h00);
		$display("test gap length zero done");
		wr(`RSI_ADDR_IEN, 8'h80);
		push(1'b0, 1'b1, 8'h3c, 8);
		push(1'b0, 1'b1, 8'hc3, 8);
		pin(1'b0, 1'b1);
		rd(`RSI_ADDR_STAT, 8'h0d);
		rd(`RSI_ADDR_DATA_A, 8'hc3);
		$display("test overflow masked done");
		for (int s = 3; s >= 0; s--) begin
			wr(`RSI_ADDR_CFG, 8'(s));
			rd_raw(`RSI_ADDR_DATA_B);
			pin(s[0], 1'b1);
			rd_raw(`RSI_ADDR_STAT);
			pin(~s[0], ~s[1]);
		end
		wr(`RSI_ADDR_CFG, 8'h01);
		$display("test pin styles done");
		rd_raw(`RSI_ADDR_DATA_B);
		pin(1'b1, 1'b1);
		rx_mode = 1'b0;
		repeat (4) @(negedge clock);
		pin(1'b0, 1'b1);
		rd(`RSI_ADDR_STAT, 8'h00);
		rx_mode = 1'b1;
		rd_raw(`RSI_ADDR_STAT);
		$display("test receive off done");
		// host takes each channel A bit from the serial pins
		wr(`RSI_ADDR_CTL, 8'h02);
		c0 = ser_cnt;
		// Last channel A bit is a one, so a dead data pin cannot pass
		push(1'b0, 1'b1, 8'h01, 2);
		push(1'b1, 1'b1, 8'h00, 1);
		chk("serial count", 8'h02, 8'(ser_cnt - c0));
		chk("serial bit", 8'h01, {7'h00, ser_bit});
		$display("test bit serial done");
		summarize();
	end
endmodule : testbench
